// file: hdl/uca_params.svh
`ifndef UCA_PARAMS_SVH
`define UCA_PARAMS_SVH
`define UCA_DATA_W 32
`define UCA_SIZE_MSB 7
`define UCA_SIZE_LSB 6
`define UCA_MODE_MSB 5
`define UCA_MODE_LSB 3
`define UCA_REG_MSB 2
`define UCA_REG_LSB 0
`define UCA_SIZE_BYTE 2'b00
`define UCA_SIZE_WORD 2'b01
`define UCA_SIZE_LONG 2'b10
`define UCA_PFX_DEC 10'b0100_1000_00
`define UCA_PFX_TWOS 8'b0100_0100
`define UCA_PFX_EXTN 8'b0100_0000
`define UCA_PFX_NOT 8'b0100_0110
`define UCA_IDLE_WORD 16'h4E71
`define UCA_MODE_ABS 3'b111
`define UCA_MODE_AREG 3'b001
`define UCA_REG_ABSW 3'b000
`define UCA_REG_ABSL 3'b001
`define UCA_RESULT_RST 32'h0000_0000
`define UCA_CCR_RST 5'h00
`endif

// file: hdl/uca_pkg.sv
package uca_pkg;
    typedef enum logic [5:0] {
        UCA_OP_NONE = 6'b00_0001,
        UCA_OP_DEC  = 6'b00_0010,
        UCA_OP_TWOS = 6'b00_0100,
        UCA_OP_EXTN = 6'b00_1000,
        UCA_OP_NOT  = 6'b01_0000,
        UCA_OP_IDLE = 6'b10_0000
    } uca_op_t;

    typedef enum logic [2:0] {
        UCA_ST_IDLE  = 3'b001,
        UCA_ST_DRAIN = 3'b010,
        UCA_ST_DONE  = 3'b100
    } uca_state_t;

    // Condition codes in the order extend, negative, zero, overflow, carry.
    typedef struct packed {
        logic x;
        logic n;
        logic z;
        logic v;
        logic c;
    } uca_ccr_t;

    typedef struct packed {
        logic [15:0] opword;
        logic [31:0] operand;
        uca_ccr_t ccr;
    } uca_req_t;
endpackage : uca_pkg

// file: hdl/uca_alu.sv
`timescale 1ns/10ps
`include "uca_params.svh"
// Summary of operation
// - Decimal complement is byte only: zero minus destination minus extend, packed BCD.
// - Decimal complement yields tens complement with extend clear, nines with extend set.
// - Decimal complement sets carry on decimal borrow, extend copies it, zero only cleared.
// - Decimal complement and negations need a data alterable destination mode.
// - Size bits 7..6 select byte 00, word 01, long 10.
// - Negate subtracts the sized destination from zero and writes it back.
// - Negations set N, Z, V from the result; carry set unless zero; extend copies carry.
// - Extended negate subtracts destination and extend from zero at the size.
// - Idle op is unsized, leaves all flags and state, only advances past itself.
// - Idle op waits until all pending bus cycles have finished.
// - Ones complement inverts every bit of the sized destination.
// - Ones complement keeps extend, sets N and Z, clears V and C.
module uca_alu (
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic start_in,
    input wire uca_pkg::uca_req_t req_in,
    input wire logic bus_busy_in,
    output logic done_out,
    output logic write_out,
    output logic illegal_out,
    output logic [31:0] result_out,
    output uca_pkg::uca_ccr_t ccr_out
);
    ////////////////////////////////////////////////////////////////////////////
    uca_pkg::uca_op_t op;
    logic [15:0] ow;
    logic [1:0] sz;
    logic [2:0] md;
    logic [2:0] rg;
    logic ea_ok;
    logic sz_ok;
    always_comb
    begin
        ow = req_in.opword;
        sz = ow[`UCA_SIZE_MSB:`UCA_SIZE_LSB];
        md = ow[`UCA_MODE_MSB:`UCA_MODE_LSB];
        rg = ow[`UCA_REG_MSB:`UCA_REG_LSB];
        op = uca_pkg::UCA_OP_NONE;
        if (ow == `UCA_IDLE_WORD)
            op = uca_pkg::UCA_OP_IDLE;
        else if (ow[15:6] == `UCA_PFX_DEC)
            op = uca_pkg::UCA_OP_DEC;
        else if (ow[15:8] == `UCA_PFX_TWOS)
            op = uca_pkg::UCA_OP_TWOS;
        else if (ow[15:8] == `UCA_PFX_EXTN)
            op = uca_pkg::UCA_OP_EXTN;
        else if (ow[15:8] == `UCA_PFX_NOT)
            op = uca_pkg::UCA_OP_NOT;
        // Data alterable: no address register, only absolute word and long in mode 111.
        ea_ok = (md != `UCA_MODE_AREG) && ((md != `UCA_MODE_ABS) ||
            (rg == `UCA_REG_ABSW) || (rg == `UCA_REG_ABSL));
        sz_ok = (sz != 2'b11);
    end

    ////////////////////////////////////////////////////////////////////////////
    logic [31:0] mask;
    logic [31:0] signb;
    logic [32:0] diff;
    logic [31:0] res;
    logic [7:0] bcd;
    logic lo_b;
    logic hi_b;
    logic [4:0] lo_d;
    logic [4:0] hi_d;
    logic [3:0] lo_fix;
    logic [3:0] hi_fix;
    logic dec_borrow;
    logic ovf;
    logic nz;
    uca_pkg::uca_ccr_t cc;
    uca_pkg::uca_ccr_t ci;
    logic bad;
    always_comb
    begin
        ci = req_in.ccr;
        case (sz)
            `UCA_SIZE_BYTE: mask = 32'h0000_00FF;
            `UCA_SIZE_WORD: mask = 32'h0000_FFFF;
            default: mask = 32'hFFFF_FFFF;
        endcase
        case (sz)
            `UCA_SIZE_BYTE: signb = 32'h0000_0080;
            `UCA_SIZE_WORD: signb = 32'h0000_8000;
            default: signb = 32'h8000_0000;
        endcase
        // Digit-wise decimal subtraction from zero, one borrow passed between digits.
        lo_d = 5'h00 - {1'b0, req_in.operand[3:0]} - {4'h0, ci.x};
        lo_b = lo_d[4];
        lo_fix = lo_b ? (lo_d[3:0] - 4'h6) : lo_d[3:0];
        hi_d = 5'h00 - {1'b0, req_in.operand[7:4]} - {4'h0, lo_b};
        hi_b = hi_d[4];
        hi_fix = hi_b ? (hi_d[3:0] - 4'h6) : hi_d[3:0];
        bcd = {hi_fix, lo_fix};
        dec_borrow = hi_b;
        // Extend enters only for the extended form.
        diff = 33'h0_0000_0000 - {1'b0, req_in.operand & mask} -
            {32'h0000_0000, (op == uca_pkg::UCA_OP_EXTN) & ci.x};
        res = 32'h0000_0000;
        cc = ci;
        bad = 1'b0;
        ovf = ((diff[31:0] & signb) != 32'h0000_0000) &&
            ((req_in.operand & signb) != 32'h0000_0000);
        nz = ((diff[31:0] & mask) != 32'h0000_0000);
        case (op)
            uca_pkg::UCA_OP_DEC:
            begin
                bad = !ea_ok;
                res = {24'h00_0000, bcd};
                cc.c = dec_borrow;
                cc.x = dec_borrow;
                if (bcd != 8'h00)
                    cc.z = 1'b0;
                // Sign and overflow are undefined here; they are simply left as they were.
            end
            uca_pkg::UCA_OP_TWOS, uca_pkg::UCA_OP_EXTN:
            begin
                bad = !ea_ok || !sz_ok;
                res = diff[31:0] & mask;
                cc.n = ((res & signb) != 32'h0000_0000);
                cc.v = ovf;
                cc.c = nz;
                cc.x = nz;
                // Zero follows the result in both forms; only the decimal form keeps it sticky.
                cc.z = !nz;
            end
            uca_pkg::UCA_OP_NOT:
            begin
                bad = !ea_ok || !sz_ok;
                res = ~req_in.operand & mask;
                cc.n = ((res & signb) != 32'h0000_0000);
                cc.z = (res == 32'h0000_0000);
                cc.v = 1'b0;
                cc.c = 1'b0;
            end
            uca_pkg::UCA_OP_IDLE:
                cc = ci;
            uca_pkg::UCA_OP_NONE:
                bad = 1'b1;
            default:
                bad = 1'b1;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    uca_pkg::uca_state_t state_reg;
    uca_pkg::uca_state_t state_next;
    logic done_reg;
    logic done_next;
    logic write_reg;
    logic write_next;
    logic illegal_reg;
    logic illegal_next;
    logic [31:0] result_reg;
    logic [31:0] result_next;
    uca_pkg::uca_ccr_t ccr_reg;
    uca_pkg::uca_ccr_t ccr_next;
    uca_pkg::uca_ccr_t held_reg;
    uca_pkg::uca_ccr_t held_next;
    always_comb
    begin
        state_next = state_reg;
        done_next = 1'b0;
        write_next = 1'b0;
        illegal_next = 1'b0;
        result_next = result_reg;
        ccr_next = ccr_reg;
        held_next = held_reg;
        case (state_reg)
            uca_pkg::UCA_ST_IDLE:
            begin
                if (start_in && op == uca_pkg::UCA_OP_IDLE)
                begin
                    held_next = ci;
                    if (bus_busy_in)
                        state_next = uca_pkg::UCA_ST_DRAIN;
                    else
                    begin
                        done_next = 1'b1;
                        ccr_next = ci;
                    end
                end
                else if (start_in)
                begin
                    done_next = 1'b1;
                    illegal_next = bad;
                    write_next = !bad;
                    // A refused instruction must not disturb flags or the destination.
                    if (!bad)
                    begin
                        result_next = res;
                        ccr_next = cc;
                    end
                    else
                        ccr_next = ci;
                end
            end
            uca_pkg::UCA_ST_DRAIN:
            begin
                if (!bus_busy_in)
                begin
                    done_next = 1'b1;
                    ccr_next = held_reg;
                    state_next = uca_pkg::UCA_ST_IDLE;
                end
            end
            default:
                state_next = uca_pkg::UCA_ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_in)
    begin
        if (!nrst_in)
        begin
            state_reg <= uca_pkg::UCA_ST_IDLE;
            done_reg <= 1'b0;
            write_reg <= 1'b0;
            illegal_reg <= 1'b0;
            result_reg <= `UCA_RESULT_RST;
            ccr_reg <= `UCA_CCR_RST;
            held_reg <= `UCA_CCR_RST;
        end
        else
        begin
            state_reg <= state_next;
            done_reg <= done_next;
            write_reg <= write_next;
            illegal_reg <= illegal_next;
            result_reg <= result_next;
            ccr_reg <= ccr_next;
            held_reg <= held_next;
        end
    end

    assign done_out = done_reg;
    assign write_out = write_reg;
    assign illegal_out = illegal_reg;
    assign result_out = result_reg;
    assign ccr_out = ccr_reg;
endmodule : uca_alu

// file: verification/uca_bus_model.sv
`timescale 1ns/10ps
module uca_bus_model (
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic go_in,
    input wire logic [3:0] len_in,
    output logic bus_busy_out
);
    logic [3:0] cnt_reg;
    // Pending cycles retire one a clock, so the drain time is exact.
    always_ff @(posedge core_clk_in)
    begin
        if (!nrst_in) cnt_reg <= 4'h0;
        else if (go_in) cnt_reg <= len_in;
        else if (cnt_reg != 4'h0) cnt_reg <= cnt_reg - 4'h1;
    end
    assign bus_busy_out = cnt_reg != 4'h0;
endmodule : uca_bus_model

// file: verification/uca_alu_sva.sv
`timescale 1ns/10ps
module uca_alu_chk (
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic start_in,
    input wire uca_pkg::uca_req_t req_in,
    input wire logic bus_busy_in,
    input wire logic done_out,
    input wire logic write_out,
    input wire logic illegal_out,
    input wire logic [31:0] result_out,
    input wire uca_pkg::uca_ccr_t ccr_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!nrst_in);
    wire logic [7:0] pfx = req_in.opword[15:8];
    wire logic idle = start_in && req_in.opword == 16'h4E71;
    ////////////////////////////////////////////////////////////////////////////////
    chk_answer_time: assert property (start_in && !idle |=> done_out)
        else $error("no answer one cycle after request");
    chk_write_qual: assert property (write_out |-> done_out && !illegal_out)
        else $error("write without a clean answer");
    chk_size_refuse: assert property (start_in && pfx inside {8'h44, 8'h40, 8'h46}
        && req_in.opword[7:6] == 2'b11 |=> illegal_out && !write_out) else $error("size 11 taken");
    chk_ea_refuse: assert property (start_in && pfx == 8'h44
        && req_in.opword[5:3] == 3'h1 |=> illegal_out)
        else $error("address register destination taken");
    chk_not_flags: assert property (start_in && pfx == 8'h46 ##1 write_out
        |-> !ccr_out.v && !ccr_out.c && ccr_out.x == $past(req_in.ccr.x))
        else $error("complement flags wrong");
    chk_neg_carry: assert property (start_in && pfx inside {8'h44, 8'h40}
        ##1 write_out |-> ccr_out.c == (result_out != 0) && ccr_out.x == ccr_out.c
        && ccr_out.z == (result_out == 0)) else $error("negate carry or zero wrong");
    chk_dec_zero: assert property (start_in && req_in.opword[15:6] == 10'h120
        ##1 write_out |-> ccr_out.x == ccr_out.c && result_out[31:8] == 24'h0
        && (result_out[7:0] != 0 ? !ccr_out.z : ccr_out.z == $past(req_in.ccr.z)))
        else $error("decimal flags wrong");
    chk_idle_flags: assert property (idle && !bus_busy_in |=> done_out && !write_out
        && ccr_out == $past(req_in.ccr)) else $error("idle op changed state");
    chk_idle_hold: assert property (idle && bus_busy_in |=> !done_out)
        else $error("idle op ran over pending bus cycles");
    chk_result_keep: assert property (!write_out |-> $stable(result_out))
        else $error("result changed without write");
    cover property (idle && bus_busy_in);
    cover property (illegal_out);
    cover property (write_out && result_out == 0);
endmodule : uca_alu_chk
bind uca_alu uca_alu_chk uca_alu_chk_i (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
    .start_in(start_in), .req_in(req_in), .bus_busy_in(bus_busy_in), .done_out(done_out),
    .write_out(write_out), .illegal_out(illegal_out), .result_out(result_out),
    .ccr_out(ccr_out));

// file: verification/tb.sv
`timescale 1ns/10ps
module tb;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic start = 1'b0;
    logic go = 1'b0;
    logic [3:0] len = 4'h0;
    uca_pkg::uca_req_t req = '0;
    logic busy, done, wr, ill;
    logic [31:0] res, g_res;
    uca_pkg::uca_ccr_t ccr;
    logic [6:0] g_fl;
    int errors = 0;
    int n_checks = 0;
    int cycles = 0;
    int lat;
    always #50 clk = ~clk;
    uca_bus_model uca_bus_model_i (.core_clk_in(clk), .nrst_in(nrst), .go_in(go), .len_in(len),
        .bus_busy_out(busy));
    uca_alu uca_alu_i (.core_clk_in(clk), .nrst_in(nrst), .start_in(start), .req_in(req),
        .bus_busy_in(busy), .done_out(done), .write_out(wr), .illegal_out(ill), .result_out(res),
        .ccr_out(ccr));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        if (errors == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : complete_run
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected word at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_word
    task automatic cmp_flags(input logic [6:0] got, input logic [6:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected flags at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_flags
    // The answer is sampled at the falling edge so it never races the launching edge.
    task automatic issue(input logic [15:0] ow, input logic [31:0] opd, input logic [4:0] cc);
        @(posedge clk);
        start <= 1'b1;
        req <= {ow, opd, cc};
        @(posedge clk);
        start <= 1'b0;
        lat = 0;
        @(negedge clk);
        while (done !== 1'b1 && lat < 20)
        begin
            lat++;
            @(negedge clk);
        end
        if (lat == 20)
            errors++;
        g_res = res;
        g_fl = {wr, ill, ccr};
    endtask : issue
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_dec;
        logic [7:0] dop [6] = '{8'h00, 8'h01, 8'h01, 8'h99, 8'h45, 8'h00};
        logic [7:0] dres [6] = '{8'h00, 8'h99, 8'h98, 8'h00, 8'h55, 8'h99};
        logic dx [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
        logic c, z;
        for (int i = 0; i < 6; i++)
        begin
            c = dop[i] != 8'h00 || dx[i];
            z = dres[i] == 8'h00 && i[0];
            issue(16'h4803, {24'h5A5A5A, dop[i]}, {dx[i], 1'b1, i[0], i[1], 1'b0});
            cmp_word(g_res, {24'h0, dres[i]});
            cmp_flags(g_fl, {2'b10, c, 1'b1, z, i[1], c});
        end
        // Software presets zero before a chain; two zero bytes must leave it standing.
        g_fl = 7'h04;
        for (int i = 0; i < 2; i++)
        begin
            issue(16'h4803, 32'h0000_0000, g_fl[4:0]);
            cmp_flags(g_fl, 7'h44);
        end
    endtask : t_dec
    // Upper operand bits carry a pattern so that a size slip shows in the result.
    task automatic t_arith;
        int w;
        logic [31:0] m, p, r;
        logic x, z, v, c;
        for (int k = 0; k < 3; k++)
            for (int s = 0; s < 3; s++)
                for (int j = 0; j < 4; j++)
                begin
                    w = 8 << s;
                    m = (w == 32) ? 32'hFFFF_FFFF : (32'h1 << w) - 32'h1;
                    p = (j == 0) ? 32'h0 : (j == 1) ? 32'h1 : (j == 2) ? 32'h1 << (w - 1) : m;
                    x = j[0];
                    r = (k == 2) ? ~p & m : (32'h0 - p - 32'(x && k == 1)) & m;
                    z = r == 0;
                    v = k != 2 && p[w - 1] && r[w - 1];
                    c = k != 2 && r != 0;
                    issue(((k == 0) ? 16'h4400 : (k == 1) ? 16'h4000 : 16'h4600) | 16'(s << 6)
                        | 16'h0002, p | (~m & 32'h5A5A_5A5A), {x, 1'b1, j[1], 2'b11});
                    cmp_word(g_res, r);
                    cmp_flags(g_fl, {2'b10, (k == 2) ? x : c, r[w - 1], z, v, c});
                end
    endtask : t_arith
    task automatic t_ea;
        logic [15:0] bad [7] = '{16'h44C2, 16'h40C2, 16'h46C2, 16'hFFFF, 16'h4E70, 16'h4809,
            16'h483C};
        logic [2:0] md, rg;
        logic ok;
        for (int i = 0; i < 16; i++)
        begin
            md = 3'(i >> 1);
            rg = i[0] ? 3'h2 : 3'h1;
            issue(16'h4400 | {10'h0, md, rg}, 32'h0000_0001, 5'h04);
            cmp_word(g_res, 32'h0000_00FF);
            ok = md != 3'h1 && !(md == 3'h7 && rg == 3'h2);
            cmp_flags(g_fl, ok ? 7'h59 : 7'h24);
        end
        for (int i = 0; i < 7; i++)
        begin
            issue(bad[i], 32'h0000_0001, 5'h0A);
            cmp_word(g_res, 32'h0000_00FF);
            cmp_flags(g_fl, 7'h2A);
        end
    endtask : t_ea
    task automatic t_idle;
        issue(16'h4E71, 32'h1234_5678, 5'h15);
        cmp_word(32'(lat), 32'h0);
        cmp_flags(g_fl, 7'h15);
        @(posedge clk);
        go <= 1'b1;
        len <= 4'h4;
        @(posedge clk);
        go <= 1'b0;
        issue(16'h4E71, 32'h0, 5'h0A);
        cmp_word(32'(lat), 32'h3);
        cmp_word(g_res, 32'h0000_00FF);
        cmp_flags(g_fl, 7'h0A);
    endtask : t_idle
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 2000)
        begin
            errors++;
            complete_run();
        end
    end
    initial
    begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        t_dec();
        t_arith();
        t_ea();
        t_idle();
        complete_run();
    end
endmodule : tb
